// file: logic/cit_defines.svh
// register indices, field positions, reset values for the interrupt tree
`ifndef CIT_DEFINES_SVH
`define CIT_DEFINES_SVH
`define CIT_IDX_TOP      8'h42
`define CIT_IDX_CHIP_WIDE_SUMMARY     8'h43
`define CIT_IDX_INCLK    8'h44
`define CIT_IDX_OUTCLK   8'h45
`define CIT_IDX_ALOOP    8'h46
`define CIT_IDX_DLOOP    8'h47
`define CIT_IDX_LOCK     8'h48
`define CIT_IDX_PINCTL   8'h50
`define CIT_TOP_CHIP_WIDE_SUMMARY     6
`define CIT_TOP_OUT      5
`define CIT_TOP_IN       4
`define CIT_TOP_DLOOP    3
`define CIT_TOP_ALOOP    2
`define CIT_TOP_IE       1
`define CIT_TOP_INT      0
`define CIT_CHIP_WIDE_SUMMARY_BOOT    7
`define CIT_CHIP_WIDE_SUMMARY_PHASE   1
`define CIT_CHIP_WIDE_SUMMARY_MEAS    0
`define CIT_LK_EN2       6
`define CIT_LK_CHG2      5
`define CIT_LK_NOW2      4
`define CIT_LK_BOTH      3
`define CIT_LK_EN1       2
`define CIT_LK_CHG1      1
`define CIT_LK_NOW1      0
`define CIT_PIN_ROUTE    0
`define CIT_PIN_INVERT   1
`define CIT_RST_REG      8'h00
`define CIT_RESP_OKAY    2'b00
`define CIT_RESP_SLVERR  2'b10
`define CIT_SYNC_STAGES  2
`endif

// file: logic/cit_pkg.sv
// types shared by the interrupt tree
package cit_pkg;
  typedef logic [7:0] cit_byte_t;
  // latched status and enable bits handed in by the sibling blocks
  typedef struct packed {
    logic            boot_done;
    logic            adj_latched;
    logic            adj_enable;
    logic            rdy_latched;
    logic            rdy_enable;
    logic [2:0]      val_latched;
    logic [2:0]      val_enable;
    logic [2:0][7:0] out_latched;
    logic [2:0][7:0] out_enable;
    logic [7:0]      dl_latched_a;
    logic [7:0]      dl_latched_b;
    logic [7:0]      dl_enable_a;
    logic [7:0]      dl_enable_b;
  } cit_src_s;
  // real-time lock levels from the loops, not on this clock
  typedef struct packed {
    logic first_lock;
    logic second_lock;
    logic dloop_lock;
  } cit_lock_s;
endpackage : cit_pkg

// file: logic/cit_top.sv
// interrupt aggregation tree with lock status and axi4-lite slave
//
// Overview of operation
// - chip-wide summary is OR of global status bits
// - output-side summary is OR of output status
// - input-side summary is OR of input status
// - digital-loop summary is OR of its status
// - analog-loop summary is OR of its status
// - master enable bit gates the master flag
// - master flag is summaries ORed, ANDed with enable
// - master flag can drive a general-purpose pin
// - boot complete cleared at reset, set when boot ends
// - phase-shift summary is latched bit AND enable
// - phase-measure summary is latched bit AND enable
// - per-input summary is validity change AND enable
// - per-output summary is any latched AND enable
// - analog-loop status bit is lock latches AND enables
// - digital-loop status bit is latched AND enable pairs
// - second-lock enable gates the second-lock change latch into the analog-loop summary; the latch itself sets regardless
// - second-lock latch sets on any second-lock level change
// - writing one clears second-lock latch, zero keeps
// - combined lock reads one when first, second and digital-loop locks all hold
// - first-lock latch sets on change, write-one clears
`timescale 1ns/10ps
`include "cit_defines.svh"

module cit_top #(
  parameter int ADDR_W = 12
) (
  input  wire logic              CLK,
  input  wire logic              ARST_N,
  input  wire cit_pkg::cit_src_s  SRC,
  input  wire cit_pkg::cit_lock_s LOCK,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  output logic                   IRQ_PIN_O,
  output logic                   IRQ_PIN_OE
);

  // index is taken from address bits 9:2, so byte address needs ten bits
  if (ADDR_W < 10)
  begin : g_addr_check
    $error("cit_top: ADDR_W must be at least 10");
  end

  // lock synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       lk1_prev_q;
  logic       lk2_prev_q;

  // software-visible state
  logic       master_en_q;
  logic       boot_q;
  logic       en1_q;
  logic       en2_q;
  logic       chg1_q;
  logic       chg2_q;
  logic       route_q;
  logic       invert_q;

  // bus state
  logic              aw_full_q;
  logic              w_full_q;
  logic [7:0]        aw_idx_q;
  logic [7:0]        w_byte_q;
  logic              w_lane_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              awready_q;
  logic              wready_q;
  logic              arready_q;
  logic              rvalid_q;
  logic [31:0]       rdata_q;
  logic [1:0]        rresp_q;
  logic              irq_q;
  logic              irq_oe_q;

  // combinational
  logic       lk1_now;
  logic       lk2_now;
  logic       both_now;
  logic       phase_sum;
  logic       meas_sum;
  logic [2:0] in_sum;
  logic [2:0] out_sum;
  logic       aloop_sum;
  logic       dloop_sum;
  logic       chip_wide_summary_top;
  logic       out_top;
  logic       in_top;
  logic       dloop_top;
  logic       aloop_top;
  logic       master_flag;
  logic       aw_take;
  logic       w_take;
  logic       wr_fire;
  logic       aw_full_d;
  logic       w_full_d;
  logic       bvalid_d;
  logic       ar_take;
  logic       rvalid_d;
  logic       wr_lane;
  logic [7:0] wr_byte;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic       wr_mapped;
  logic       rd_mapped;
  logic [7:0] rd_byte;

  cit_pkg::cit_byte_t top_reg;
  cit_pkg::cit_byte_t chip_wide_summary_reg;
  cit_pkg::cit_byte_t lock_reg;

  // two flops per lock level; only the second stage is read
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {LOCK.first_lock, LOCK.second_lock, LOCK.dloop_lock};
      sync2_q <= sync1_q;
    end
  end

  assign lk1_now  = sync2_q[2];
  assign lk2_now  = sync2_q[1];
  assign both_now = lk1_now & lk2_now & sync2_q[0];

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      lk1_prev_q <= 1'b0;
      lk2_prev_q <= 1'b0;
    end
    else
    begin
      lk1_prev_q <= lk1_now;
      lk2_prev_q <= lk2_now;
    end
  end

  // summaries stay combinational so they fall as soon as sources clear
  assign phase_sum = SRC.adj_latched & SRC.adj_enable;
  assign meas_sum  = SRC.rdy_latched & SRC.rdy_enable;
  assign in_sum    = SRC.val_latched & SRC.val_enable;

  for (genvar i = 0; i < 3; i++)
  begin : g_out
    assign out_sum[i] = |(SRC.out_latched[i] & SRC.out_enable[i]);
  end

  assign aloop_sum = (chg1_q & en1_q) | (chg2_q & en2_q);
  assign dloop_sum = |((SRC.dl_latched_a & SRC.dl_enable_a)
                     | (SRC.dl_latched_b & SRC.dl_enable_b));

  assign chip_wide_summary_top  = boot_q | phase_sum | meas_sum;
  assign out_top   = |out_sum;
  assign in_top    = |in_sum;
  assign dloop_top = dloop_sum;
  assign aloop_top = aloop_sum;

  assign master_flag = master_en_q
                     & (chip_wide_summary_top | out_top | in_top | dloop_top | aloop_top);

  // write channel: address and data accepted in either order
  assign aw_take = S_AXI_AWVALID & awready_q;
  assign w_take  = S_AXI_WVALID & wready_q;
  assign wr_fire = (aw_full_q | aw_take) & (w_full_q | w_take) & !bvalid_q;

  assign wr_idx  = aw_take ? S_AXI_AWADDR[9:2] : aw_idx_q;
  assign wr_byte = w_take ? S_AXI_WDATA[7:0] : w_byte_q;
  assign wr_lane = w_take ? S_AXI_WSTRB[0] : w_lane_q;

  always_comb
  begin
    aw_full_d = (aw_full_q | aw_take) & !wr_fire;
    w_full_d  = (w_full_q | w_take) & !wr_fire;
    bvalid_d  = wr_fire | (bvalid_q & !S_AXI_BREADY);
  end

  always_comb
  begin
    wr_mapped = 1'b0;
    case (wr_idx)
      `CIT_IDX_TOP,
      `CIT_IDX_CHIP_WIDE_SUMMARY,
      `CIT_IDX_INCLK,
      `CIT_IDX_OUTCLK,
      `CIT_IDX_ALOOP,
      `CIT_IDX_DLOOP,
      `CIT_IDX_LOCK,
      `CIT_IDX_PINCTL: wr_mapped = 1'b1;
      default:         wr_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      w_byte_q  <= 8'h00;
      w_lane_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `CIT_RESP_OKAY;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end
    else
    begin
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      if (aw_take)
      begin
        aw_idx_q <= S_AXI_AWADDR[9:2];
      end
      if (w_take)
      begin
        w_byte_q <= S_AXI_WDATA[7:0];
        w_lane_q <= S_AXI_WSTRB[0];
      end
      bvalid_q  <= bvalid_d;
      if (wr_fire)
      begin
        bresp_q <= wr_mapped ? `CIT_RESP_OKAY : `CIT_RESP_SLVERR;
      end
      // one write in flight: readies drop until the response is taken
      awready_q <= !aw_full_d & !bvalid_d;
      wready_q  <= !w_full_d & !bvalid_d;
    end
  end

  // writable control bits; only byte lane 0 carries register data
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      master_en_q <= 1'b0;
      en1_q       <= 1'b0;
      en2_q       <= 1'b0;
      route_q     <= 1'b0;
      invert_q    <= 1'b0;
    end
    else if (wr_fire && wr_lane)
    begin
      if (wr_idx == `CIT_IDX_TOP)
      begin
        master_en_q <= wr_byte[`CIT_TOP_IE];
      end
      if (wr_idx == `CIT_IDX_LOCK)
      begin
        en1_q <= wr_byte[`CIT_LK_EN1];
        en2_q <= wr_byte[`CIT_LK_EN2];
      end
      if (wr_idx == `CIT_IDX_PINCTL)
      begin
        route_q  <= wr_byte[`CIT_PIN_ROUTE];
        invert_q <= wr_byte[`CIT_PIN_INVERT];
      end
    end
  end

  // lock change latches: a change in the clear cycle keeps the bit set
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      chg1_q <= 1'b0;
      chg2_q <= 1'b0;
    end
    else
    begin
      if (lk1_now != lk1_prev_q)
      begin
        chg1_q <= 1'b1;
      end
      else if (wr_fire && wr_lane && wr_idx == `CIT_IDX_LOCK && wr_byte[`CIT_LK_CHG1])
      begin
        chg1_q <= 1'b0;
      end
      if (lk2_now != lk2_prev_q)
      begin
        chg2_q <= 1'b1;
      end
      else if (wr_fire && wr_lane && wr_idx == `CIT_IDX_LOCK && wr_byte[`CIT_LK_CHG2])
      begin
        chg2_q <= 1'b0;
      end
    end
  end

  // boot done is sticky until the next device reset
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      boot_q <= 1'b0;
    end
    else if (SRC.boot_done)
    begin
      boot_q <= 1'b1;
    end
  end

  // read channel
  assign ar_take  = S_AXI_ARVALID & arready_q;
  assign rvalid_d = ar_take | (rvalid_q & !S_AXI_RREADY);
  assign rd_idx   = S_AXI_ARADDR[9:2];

  always_comb
  begin
    top_reg = `CIT_RST_REG;
    top_reg[`CIT_TOP_CHIP_WIDE_SUMMARY]  = chip_wide_summary_top;
    top_reg[`CIT_TOP_OUT]   = out_top;
    top_reg[`CIT_TOP_IN]    = in_top;
    top_reg[`CIT_TOP_DLOOP] = dloop_top;
    top_reg[`CIT_TOP_ALOOP] = aloop_top;
    top_reg[`CIT_TOP_IE]    = master_en_q;
    top_reg[`CIT_TOP_INT]   = master_flag;
  end

  always_comb
  begin
    chip_wide_summary_reg = `CIT_RST_REG;
    chip_wide_summary_reg[`CIT_CHIP_WIDE_SUMMARY_BOOT]  = boot_q;
    chip_wide_summary_reg[`CIT_CHIP_WIDE_SUMMARY_PHASE] = phase_sum;
    chip_wide_summary_reg[`CIT_CHIP_WIDE_SUMMARY_MEAS]  = meas_sum;
  end

  always_comb
  begin
    lock_reg = `CIT_RST_REG;
    lock_reg[`CIT_LK_EN2]  = en2_q;
    lock_reg[`CIT_LK_CHG2] = chg2_q;
    lock_reg[`CIT_LK_NOW2] = lk2_now;
    lock_reg[`CIT_LK_BOTH] = both_now;
    lock_reg[`CIT_LK_EN1]  = en1_q;
    lock_reg[`CIT_LK_CHG1] = chg1_q;
    lock_reg[`CIT_LK_NOW1] = lk1_now;
  end

  always_comb
  begin
    rd_byte   = 8'h00;
    rd_mapped = 1'b1;
    case (rd_idx)
      `CIT_IDX_TOP:    rd_byte = top_reg;
      `CIT_IDX_CHIP_WIDE_SUMMARY:   rd_byte = chip_wide_summary_reg;
      `CIT_IDX_INCLK:  rd_byte = {5'h00, in_sum};
      `CIT_IDX_OUTCLK: rd_byte = {5'h00, out_sum};
      `CIT_IDX_ALOOP:  rd_byte = {7'h00, aloop_sum};
      `CIT_IDX_DLOOP:  rd_byte = {7'h00, dloop_sum};
      `CIT_IDX_LOCK:   rd_byte = lock_reg;
      `CIT_IDX_PINCTL: rd_byte = {6'h00, invert_q, route_q};
      default:         rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= 32'h0000_0000;
      rresp_q   <= `CIT_RESP_OKAY;
    end
    else
    begin
      rvalid_q  <= rvalid_d;
      arready_q <= !rvalid_d;
      if (ar_take)
      begin
        rdata_q <= {24'h00_0000, rd_byte};
        rresp_q <= rd_mapped ? `CIT_RESP_OKAY : `CIT_RESP_SLVERR;
      end
    end
  end

  // pin follows the master flag one cycle later; invert suits an active-low line
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      irq_q    <= 1'b0;
      irq_oe_q <= 1'b0;
    end
    else
    begin
      irq_q    <= route_q & (master_flag ^ invert_q);
      irq_oe_q <= route_q;
    end
  end

  assign S_AXI_AWREADY = awready_q;
  assign S_AXI_WREADY  = wready_q;
  assign S_AXI_BVALID  = bvalid_q;
  assign S_AXI_BRESP   = bresp_q;
  assign S_AXI_ARREADY = arready_q;
  assign S_AXI_RVALID  = rvalid_q;
  assign S_AXI_RDATA   = rdata_q;
  assign S_AXI_RRESP   = rresp_q;
  assign IRQ_PIN_O     = irq_q;
  assign IRQ_PIN_OE    = irq_oe_q;

endmodule : cit_top

// file: sim/cit_top_props.sv
// concurrent checks on the interrupt tree ports
`timescale 1ns/10ps
`include "cit_defines.svh"
module cit_top_props #(
  parameter int ADDR_W = 12
) (
  input wire logic              CLK,
  input wire logic              ARST_N,
  input wire cit_pkg::cit_src_s SRC,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic              S_AXI_ARVALID,
  input wire logic              S_AXI_ARREADY,
  input wire logic [31:0]       S_AXI_RDATA,
  input wire logic              S_AXI_RVALID,
  input wire logic              IRQ_PIN_O,
  input wire logic              IRQ_PIN_OE
);
  logic [7:0] idx_q;
  // index of the read in flight; only one read can be open at a time
  always_ff @(posedge CLK or negedge ARST_N)
    if (!ARST_N) idx_q <= 8'h00;
    else if (S_AXI_ARVALID && S_AXI_ARREADY) idx_q <= S_AXI_ARADDR[9:2];
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // readback is fresh and sources held over the sampling cycle
  sequence s_rd(logic [7:0] i);
    $rose(S_AXI_RVALID) && $stable(SRC) && idx_q == i;
  endsequence
  a_phase_sum: assert property (s_rd(`CIT_IDX_CHIP_WIDE_SUMMARY) |->
    S_AXI_RDATA[1] == (SRC.adj_latched & SRC.adj_enable)) else $error("phase summary wrong");
  a_meas_sum: assert property (s_rd(`CIT_IDX_CHIP_WIDE_SUMMARY) |->
    S_AXI_RDATA[0] == (SRC.rdy_latched & SRC.rdy_enable)) else $error("measure summary wrong");
  a_input_sum: assert property (s_rd(`CIT_IDX_INCLK) |->
    S_AXI_RDATA[2:0] == (SRC.val_latched & SRC.val_enable)) else $error("input summary wrong");
  a_output_sum: assert property (s_rd(`CIT_IDX_OUTCLK) |-> S_AXI_RDATA[2:0] ==
    {|(SRC.out_latched[2] & SRC.out_enable[2]), |(SRC.out_latched[1] & SRC.out_enable[1]),
     |(SRC.out_latched[0] & SRC.out_enable[0])}) else $error("output summary wrong");
  a_dloop_sum: assert property (s_rd(`CIT_IDX_DLOOP) |-> S_AXI_RDATA[0] ==
    |((SRC.dl_latched_a & SRC.dl_enable_a) | (SRC.dl_latched_b & SRC.dl_enable_b))) else $error("dloop summary wrong");
  a_input_top: assert property (s_rd(`CIT_IDX_TOP) |->
    S_AXI_RDATA[4] == |(SRC.val_latched & SRC.val_enable)) else $error("top input bit wrong");
  a_master_flag: assert property (s_rd(`CIT_IDX_TOP) |->
    S_AXI_RDATA[0] == (|S_AXI_RDATA[6:2] & S_AXI_RDATA[1])) else $error("master flag wrong");
  a_enable_gate: assert property (S_AXI_RVALID && idx_q == `CIT_IDX_TOP && !S_AXI_RDATA[1] |->
    !S_AXI_RDATA[0]) else $error("flag set while disabled");
  a_pin_route: assert property (IRQ_PIN_O |-> IRQ_PIN_OE) else $error("pin high undriven");
  c_flag: cover property (s_rd(`CIT_IDX_TOP) ##0 S_AXI_RDATA[0]);
  c_chg2: cover property (s_rd(`CIT_IDX_LOCK) ##0 S_AXI_RDATA[5]);
  c_pin: cover property (IRQ_PIN_OE && IRQ_PIN_O);
endmodule : cit_top_props

// file: sim/cit_host_model.sv
// host model watching the interrupt line and the lock readback
`timescale 1ns/10ps
module cit_host_model (
  input  wire logic       clk,
  input  wire logic       pin_o,
  input  wire logic       pin_oe,
  input  wire logic [7:0] lock_rd,
  output logic            line,
  output logic            irq_seen,
  output logic            pll_locked
);
  logic last_q;
  // no pull on the line: a released pin shows the inverse so a stale level cannot pass
  always_ff @(posedge clk) if (pin_oe) last_q <= pin_o;
  assign line = pin_oe ? pin_o : ~last_q;
  always_ff @(posedge clk) irq_seen <= pin_oe & line;
  assign pll_locked = lock_rd[0] & lock_rd[4];
endmodule : cit_host_model

// file: sim/tb_top.sv
// self-checking bench for the interrupt tree
`timescale 1ns/10ps
`include "cit_defines.svh"
module tb_top;
  logic               CLK, ARST_N, line, irq_seen, pll_locked;
  cit_pkg::cit_src_s  SRC;
  cit_pkg::cit_lock_s LOCK;
  logic [11:0]        S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0]        S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0]         S_AXI_WSTRB;
  logic [1:0]         S_AXI_BRESP, S_AXI_RRESP;
  logic               S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic               S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY, IRQ_PIN_O, IRQ_PIN_OE;
  logic [7:0]         lock_rd;
  int                 failures, checks, cyc;
  cit_top cit_top_i (.CLK(CLK), .ARST_N(ARST_N), .SRC(SRC), .LOCK(LOCK), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID),
    .S_AXI_RREADY(S_AXI_RREADY), .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE(IRQ_PIN_OE));
  cit_host_model cit_host_model_i (.clk(CLK), .pin_o(IRQ_PIN_O), .pin_oe(IRQ_PIN_OE), .lock_rd(lock_rd),
    .line(line), .irq_seen(irq_seen), .pll_locked(pll_locked));
  initial
  begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  always @(posedge CLK)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      failures++;
      $display("[ERR] %0t timeout", $time);
      wrap_up();
    end
  end
  task wrap_up;
    $display("failures=%0d checks=%0d", failures, checks);
    if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task do_reset;
    ARST_N <= 1'b0;
    repeat (8) @(posedge CLK);
    ARST_N <= 1'b1;
    repeat (2) @(posedge CLK);
  endtask : do_reset
  task automatic wr(input logic [7:0] i, input logic [7:0] d, input logic [1:0] er);
    int n;
    @(posedge CLK);
    S_AXI_AWADDR <= {2'b00, i, 2'b00};
    S_AXI_WDATA <= {24'h000000, d};
    S_AXI_WSTRB <= 4'hF;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    S_AXI_BREADY <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
      if (S_AXI_AWREADY === 1'b1) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY === 1'b1) S_AXI_WVALID <= 1'b0;
    end
    while (S_AXI_BVALID !== 1'b1 && n < 40);
    S_AXI_BREADY <= 1'b0;
    // a write that never answered fails here as well
    chk({29'h0, S_AXI_BVALID, S_AXI_BRESP}, {29'h0, 1'b1, er});
  endtask : wr
  task automatic rd(input logic [7:0] i, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge CLK);
    S_AXI_ARADDR <= {2'b00, i, 2'b00};
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY <= 1'b1;
    n = 0;
    do
    begin
      @(posedge CLK);
      n++;
      if (S_AXI_ARREADY === 1'b1) S_AXI_ARVALID <= 1'b0;
    end
    while (S_AXI_RVALID !== 1'b1 && n < 40);
    chk({31'h0, S_AXI_RVALID}, 32'h1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
  endtask : rd
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(i, d, r);
    chk(d, {24'h000000, e});
    chk({30'h0, r}, {30'h0, `CIT_RESP_OKAY});
  endtask : rc
  // one source per k; with en low the vector enables (k 2 to 4) sit on neighbouring bits to catch loose pairing
  function automatic cit_pkg::cit_src_s mk(input int k, input logic en);
    mk = '0;
    mk.adj_latched = (k == 0);
    mk.adj_enable = (k == 0) & en;
    mk.rdy_latched = (k == 1);
    mk.rdy_enable = (k == 1) & en;
    mk.val_latched[1] = (k == 2);
    mk.val_enable = (k == 2) ? {1'b0, en, ~en} : 3'h0;
    mk.out_latched[2][7] = (k == 3);
    mk.out_enable[2] = (k == 3) ? {en, ~en, 6'h00} : 8'h00;
    mk.dl_latched_b[3] = (k == 4);
    mk.dl_enable_b = (k == 4) ? {4'h0, en, ~en, 2'h0} : 8'h00;
    mk.dl_enable_a = (k == 4) ? {4'h0, ~en, 3'h0} : 8'h00;
  endfunction : mk
  task automatic t_sum;
    logic [7:0] ix [5] = '{`CIT_IDX_CHIP_WIDE_SUMMARY, `CIT_IDX_CHIP_WIDE_SUMMARY, `CIT_IDX_INCLK, `CIT_IDX_OUTCLK, `CIT_IDX_DLOOP};
    logic [7:0] bv [5] = '{8'h02, 8'h01, 8'h02, 8'h04, 8'h01};
    int         tp [5] = '{6, 6, 4, 5, 3};
    logic [7:0] t;
    for (int k = 0; k < 5; k++)
    begin
      t = 8'h01 << tp[k];
      SRC <= mk(k, 1'b0);
      rc(ix[k], 8'h00);
      rc(`CIT_IDX_TOP, 8'h00);
      SRC <= mk(k, 1'b1);
      rc(ix[k], bv[k]);
      rc(`CIT_IDX_TOP, t);
      wr(`CIT_IDX_TOP, 8'hFF, `CIT_RESP_OKAY);
      rc(`CIT_IDX_TOP, t | 8'h03);
      wr(`CIT_IDX_TOP, 8'h00, `CIT_RESP_OKAY);
    end
    SRC <= '0;
  endtask : t_sum
  task automatic t_lock;
    logic [31:0] d;
    logic [1:0]  r;
    LOCK.second_lock <= 1'b1;
    repeat (5) @(posedge CLK);
    rc(`CIT_IDX_LOCK, 8'h30);
    rc(`CIT_IDX_ALOOP, 8'h00);
    wr(`CIT_IDX_LOCK, 8'h40, `CIT_RESP_OKAY);
    rc(`CIT_IDX_ALOOP, 8'h01);
    rc(`CIT_IDX_TOP, 8'h04);
    rc(`CIT_IDX_LOCK, 8'h70);
    wr(`CIT_IDX_LOCK, 8'h60, `CIT_RESP_OKAY);
    rc(`CIT_IDX_LOCK, 8'h50);
    rc(`CIT_IDX_ALOOP, 8'h00);
    LOCK.second_lock <= 1'b0;
    repeat (5) @(posedge CLK);
    rc(`CIT_IDX_LOCK, 8'h60);
    wr(`CIT_IDX_LOCK, 8'h20, `CIT_RESP_OKAY);
    LOCK.first_lock <= 1'b1;
    repeat (5) @(posedge CLK);
    rc(`CIT_IDX_LOCK, 8'h03);
    wr(`CIT_IDX_LOCK, 8'h04, `CIT_RESP_OKAY);
    rc(`CIT_IDX_ALOOP, 8'h01);
    wr(`CIT_IDX_LOCK, 8'h02, `CIT_RESP_OKAY);
    rc(`CIT_IDX_LOCK, 8'h01);
    LOCK.second_lock <= 1'b1;
    LOCK.dloop_lock <= 1'b1;
    repeat (5) @(posedge CLK);
    rc(`CIT_IDX_LOCK, 8'h39);
    // host judges lock from what it really read back
    rd(`CIT_IDX_LOCK, d, r);
    lock_rd <= d[7:0];
    @(posedge CLK);
    chk({31'h0, pll_locked}, 32'h1);
    LOCK.dloop_lock <= 1'b0;
    repeat (5) @(posedge CLK);
    rc(`CIT_IDX_LOCK, 8'h31);
    wr(`CIT_IDX_LOCK, 8'h20, `CIT_RESP_OKAY);
  endtask : t_lock
  task t_pin;
    SRC <= mk(0, 1'b1);
    wr(`CIT_IDX_TOP, 8'h02, `CIT_RESP_OKAY);
    wr(`CIT_IDX_PINCTL, 8'h01, `CIT_RESP_OKAY);
    repeat (2) @(posedge CLK);
    chk({30'h0, IRQ_PIN_OE, IRQ_PIN_O}, 32'h3);
    chk({31'h0, irq_seen}, 32'h1);
    wr(`CIT_IDX_PINCTL, 8'h03, `CIT_RESP_OKAY);
    repeat (2) @(posedge CLK);
    chk({30'h0, IRQ_PIN_OE, IRQ_PIN_O}, 32'h2);
    SRC <= '0;
    repeat (3) @(posedge CLK);
    chk({30'h0, IRQ_PIN_OE, IRQ_PIN_O}, 32'h3);
    wr(`CIT_IDX_PINCTL, 8'h00, `CIT_RESP_OKAY);
    repeat (2) @(posedge CLK);
    chk({30'h0, IRQ_PIN_OE, IRQ_PIN_O}, 32'h0);
  endtask : t_pin
  task automatic t_misc;
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h49, 8'hFF, `CIT_RESP_SLVERR);
    rd(8'h49, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, {30'h0, `CIT_RESP_SLVERR});
    wr(`CIT_IDX_CHIP_WIDE_SUMMARY, 8'hFF, `CIT_RESP_OKAY);
    rc(`CIT_IDX_CHIP_WIDE_SUMMARY, 8'h00);
    SRC.boot_done <= 1'b1;
    @(posedge CLK);
    SRC.boot_done <= 1'b0;
    rc(`CIT_IDX_CHIP_WIDE_SUMMARY, 8'h80);
    rc(`CIT_IDX_TOP, 8'h43);
    do_reset();
    rc(`CIT_IDX_CHIP_WIDE_SUMMARY, 8'h00);
  endtask : t_misc
  initial
  begin
    ARST_N = 1'b0;
    SRC = '0;
    LOCK = '0;
    lock_rd = 8'h00;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    do_reset();
    for (int i = 8'h42; i <= 8'h48; i++) rc(8'(i), 8'h00);
    t_sum();
    t_lock();
    t_pin();
    t_misc();
    wrap_up();
  end
endmodule : tb_top
bind cit_top cit_top_props #(.ADDR_W(ADDR_W)) cit_top_props_i (.CLK(CLK), .ARST_N(ARST_N), .SRC(SRC),
  .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .IRQ_PIN_O(IRQ_PIN_O), .IRQ_PIN_OE(IRQ_PIN_OE));
